// file: pkg/tpc_pkg.sv
// Shared types and constants for the transport packet capture block.
package tpc_pkg;

  // ---------------------------------------------------------------
  // Widths and sizes
  // ---------------------------------------------------------------
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned SIZE_W     = 16;
  localparam int unsigned LANE_W     = 3;
  localparam int unsigned FIFO_DEPTH = 80;
  localparam int unsigned LINK_W     = 12;

  localparam logic [LANE_W-1:0]     LANE_LAST  = 3'h3;
  localparam logic [LANE_W-1:0]     LANE_NONE  = 3'h0;
  localparam logic [WORD_BYTES-1:0] BE_ALL     = 4'hf;
  localparam logic [ADDR_W-1:0]     WORD_STEP  = 32'h0000_0004;
  localparam logic [SIZE_W-1:0]     COUNT_ONE  = 16'h0001;
  localparam logic [SIZE_W-1:0]     COUNT_NONE = 16'h0000;

  // ---------------------------------------------------------------
  // Bit positions inside the sampled link vector
  // ---------------------------------------------------------------
  localparam int unsigned LK_CLK   = 11;
  localparam int unsigned LK_VALID = 10;
  localparam int unsigned LK_START = 9;
  localparam int unsigned LK_ERR   = 8;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TPC_IDLE  = 3'b000,
    TPC_HUNT  = 3'b001,
    TPC_CAPT  = 3'b011,
    TPC_FLUSH = 3'b010,
    TPC_DONE  = 3'b110
  } tpc_state_type;

  typedef struct packed {
    logic              start;
    logic              err;
    logic [BYTE_W-1:0] data;
  } tpc_entry_type;

  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [SIZE_W-1:0] size;
  } tpc_chan_type;

  typedef struct packed {
    logic [ADDR_W-1:0]            addr;
    logic [WORD_BYTES*BYTE_W-1:0] data;
    logic [WORD_BYTES-1:0]        be;
  } tpc_mem_wr_type;

endpackage : tpc_pkg

// file: rtl/tpc_fifo.sv
// Synchronous FIFO with a registered read stage, used as the capture buffer.
`timescale 1ns/1ps
module tpc_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 80
) (
  input  wire logic             clk_i,      // System clock.
  input  wire logic             nrst_i,     // Synchronous reset, active low.
  input  wire logic             in_valid_i, // Write request.
  output logic                  in_ready_o, // Room for one more entry.
  input  wire logic [WIDTH-1:0] in_data_i,  // Write data.
  output logic                  out_valid_o,// Read stage holds an entry.
  input  wire logic             out_ready_i,// Reader takes the entry.
  output logic      [WIDTH-1:0] out_data_o  // Registered read data.
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wptr;
  logic [PTR_W-1:0] rptr;
  logic [CNT_W-1:0] count;
  logic             push;
  logic             load;

  // Full is reported only when the array itself is full, so the writer
  // never overwrites a stored entry.
  assign in_ready_o = (count != CNT_FULL);
  assign push       = in_valid_i & in_ready_o;
  assign load       = (count != '0) & (~out_valid_o | out_ready_i);

  // ---------------------------------------------------------------
  // Storage array and pointers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == PTR_LAST) ? '0 : wptr + 1'b1;
      end
      if (load) begin
        rptr <= (rptr == PTR_LAST) ? '0 : rptr + 1'b1;
      end
      count <= count + CNT_W'(push) - CNT_W'(load);
    end
  end

  // The read stage is a register so the reader sees clean data.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (load) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem[rptr];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_fifo_depth: assert property (@(posedge clk_i) disable iff (!nrst_i)
    count <= CNT_FULL) else $error("fifo count above depth");
  a_fifo_full_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (in_valid_i && !in_ready_o && !load) |=> count == CNT_FULL)
    else $error("full fifo lost or gained entries");
  c_fifo_full: cover property (@(posedge clk_i) disable iff (!nrst_i)
    count == CNT_FULL);

endmodule : tpc_fifo

// file: rtl/tpc_capture.sv
// Transport packet capture: byte link sampling, buffering and word writes.
`timescale 1ns/1ps
// What this block does
// - Takes eight data bits plus byte-valid, packet-start and packet-error inputs.
// - All link inputs are sampled only at rising edges of the byte clock.
// - Bytes with byte-valid low are null and are not stored.
// - Valid bytes arriving while the input FIFO is full are dropped.
// - Input FIFO holds 81 bytes (80 entries plus the read stage) before a transfer must start.
// - Capture starts only after a channel request gives base and size.
// - Discard until packet-start rises, then capture up to the size.
// - Captured bytes are written to memory as 32-bit words.
// - At size reached, send the last word: full, or partial if bytes are left over.
// - Channel acknowledge only after all received bytes are written.
// - New packet start mid-packet restarts capture into the same buffer.
// - Packet-error during a packet aborts it and rewaits, same buffer.
// - Packet-error is ignored while packet-start is low.
// - Packet-error at the packet-start rise prevents that packet starting.
module tpc_capture
  import tpc_pkg::*;
(
  input  wire logic              clk_i,                 // System clock, 50 MHz.
  input  wire logic              nrst_i,                // Synchronous reset, active low.
  input  wire logic              stream_byte_clock_i,   // Byte clock from the front end.
  input  wire logic              stream_byte_valid_i,   // High marks a real byte.
  input  wire logic [BYTE_W-1:0] stream_data_in_i,      // Byte data.
  input  wire logic              stream_packet_error_i, // Packet in error.
  input  wire logic              stream_packet_start_i, // Packet start level.
  input  wire logic              chan_valid_i,          // Channel input request.
  input  wire tpc_chan_type      chan_req_i,            // Buffer base and byte count.
  output logic                   chan_ready_o,          // Request taken this cycle.
  output logic                   chan_ack_o,            // Transfer complete pulse.
  output logic                   mem_wr_valid_o,        // Memory write request.
  output tpc_mem_wr_type         mem_wr_o,              // Address, data, lanes.
  input  wire logic              mem_wr_ready_i,        // Memory accepts the write.
  output logic                   drop_o                 // Byte lost to a full FIFO.
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Places a byte in its lane of a little-endian word.
  function automatic logic [WORD_BYTES*BYTE_W-1:0] put_byte(
    input logic [WORD_BYTES*BYTE_W-1:0] word,
    input logic [LANE_W-1:0]            lane,
    input logic [BYTE_W-1:0]            b
  );
    logic [WORD_BYTES*BYTE_W-1:0] w;
    w = word;
    w[lane[1:0]*BYTE_W +: BYTE_W] = b;
    return w;
  endfunction : put_byte

  // Byte enables for the lowest lanes held in a partial word.
  function automatic logic [WORD_BYTES-1:0] lane_mask(
    input logic [LANE_W-1:0] lanes
  );
    logic [WORD_BYTES-1:0] m;
    m = '0;
    for (int i = 0; i < WORD_BYTES; i++) begin
      m[i] = (LANE_W'(i) < lanes);
    end
    return m;
  endfunction : lane_mask

  // ---------------------------------------------------------------
  // Link sampling
  // ---------------------------------------------------------------
  logic [LINK_W-1:0] link_s1;
  logic [LINK_W-1:0] link_s2;
  logic [LINK_W-1:0] link_s3;
  logic              prev_start;
  logic              byte_edge;
  tpc_entry_type     in_entry;
  logic              in_ready;
  logic              push;

  // Every link pin is an outside level, so all pass two flip-flops first.
  // A third stage lines the data up with the byte clock still low, so the
  // byte taken is the one set up before the rising edge, not the next one.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      link_s1 <= '0;
      link_s2 <= '0;
      link_s3 <= '0;
    end else begin
      link_s1 <= {stream_byte_clock_i, stream_byte_valid_i,
                  stream_packet_start_i, stream_packet_error_i,
                  stream_data_in_i};
      link_s2 <= link_s1;
      link_s3 <= link_s2;
    end
  end

  // Rising edges of the byte clock are the only sample points.
  assign byte_edge = link_s2[LK_CLK] & ~link_s3[LK_CLK];

  // The packet-start level seen at the previous byte clock edge.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      prev_start <= 1'b0;
    end else if (byte_edge) begin
      prev_start <= link_s3[LK_START];
    end
  end

  // Start marks the low-to-high change; error only counts inside a packet.
  always_comb begin
    in_entry.data  = link_s3[BYTE_W-1:0];
    in_entry.start = link_s3[LK_START] & ~prev_start;
    in_entry.err   = link_s3[LK_ERR] & link_s3[LK_START];
  end

  // Null bytes and bytes meeting a full FIFO are never stored.
  assign push   = byte_edge & link_s3[LK_VALID] & in_ready;
  assign drop_o = byte_edge & link_s3[LK_VALID] & ~in_ready;

  // ---------------------------------------------------------------
  // Input buffer
  // ---------------------------------------------------------------
  tpc_entry_type out_entry;
  logic          out_valid;
  logic          pop;

  // The buffer fills while no transfer is running, which gives software
  // time to issue the next request between packets.
  tpc_fifo #(
    .WIDTH ($bits(tpc_entry_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (byte_edge & link_s3[LK_VALID]),
    .in_ready_o  (in_ready),
    .in_data_i   (in_entry),
    .out_valid_o (out_valid),
    .out_ready_i (pop),
    .out_data_o  (out_entry)
  );

  // ---------------------------------------------------------------
  // Capture decisions
  // ---------------------------------------------------------------
  tpc_state_type                state;
  logic [ADDR_W-1:0]            base;
  logic [SIZE_W-1:0]            size;
  logic [SIZE_W-1:0]            byte_cnt;
  logic [ADDR_W-1:0]            waddr;
  logic [WORD_BYTES*BYTE_W-1:0] acc;
  logic [LANE_W-1:0]            lanes;
  logic                         wr_valid;
  logic                         active;
  logic                         store;
  logic                         first;
  logic                         abort;
  logic                         word_done;
  logic                         last;
  logic                         flush_part;
  logic [SIZE_W-1:0]            cnt_after;
  logic [LANE_W-1:0]            lane_at;
  logic [ADDR_W-1:0]            waddr_at;
  logic [WORD_BYTES*BYTE_W-1:0] acc_after;

  // A pending word write stalls the buffer, so back-pressure from memory
  // reaches the FIFO and, once that is full, bytes from the link are dropped.
  assign active = (state == TPC_HUNT) | (state == TPC_CAPT);
  assign pop    = out_valid & active & ~wr_valid;

  always_comb begin
    first      = pop & out_entry.start & ~out_entry.err;
    store      = pop & ~out_entry.err & ((state == TPC_CAPT) | out_entry.start);
    abort      = pop & out_entry.err & (state == TPC_CAPT);
    cnt_after  = first ? COUNT_ONE : byte_cnt + COUNT_ONE;
    lane_at    = first ? LANE_NONE : lanes;
    waddr_at   = first ? base : waddr;
    acc_after  = put_byte(first ? '0 : acc, lane_at, out_entry.data);
    word_done  = store & (lane_at == LANE_LAST);
    last       = store & (cnt_after == size);
    flush_part = (state == TPC_FLUSH) & ~wr_valid & (lanes != LANE_NONE);
  end

  // ---------------------------------------------------------------
  // Transfer sequencing
  // ---------------------------------------------------------------
  // Hunting throws bytes away until a clean packet start; an error start
  // is skipped, and a start with a live packet begins it over again.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state <= TPC_IDLE;
    end else begin
      case (state)
        TPC_IDLE: begin
          if (chan_valid_i) begin
            state <= (chan_req_i.size == COUNT_NONE) ? TPC_FLUSH : TPC_HUNT;
          end
        end
        TPC_HUNT: begin
          if (first) begin
            state <= last ? TPC_FLUSH : TPC_CAPT;
          end
        end
        TPC_CAPT: begin
          if (abort) begin
            state <= TPC_HUNT;
          end else if (last) begin
            state <= TPC_FLUSH;
          end
        end
        TPC_FLUSH: begin
          if (!wr_valid && lanes == LANE_NONE) begin
            state <= TPC_DONE;
          end
        end
        TPC_DONE: begin
          state <= TPC_IDLE;
        end
        default: begin
          state <= TPC_IDLE;
        end
      endcase
    end
  end

  // Channel request fields are kept for the whole transfer.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      base <= '0;
      size <= '0;
    end else if (state == TPC_IDLE && chan_valid_i) begin
      base <= chan_req_i.base;
      size <= chan_req_i.size;
    end
  end

  // Byte count, word address and assembly word for the packet in hand.
  // Restart and abort both fall back to the buffer base.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      byte_cnt <= '0;
      waddr    <= '0;
      acc      <= '0;
      lanes    <= '0;
    end else if (state == TPC_IDLE) begin
      byte_cnt <= '0;
      waddr    <= chan_req_i.base;
      lanes    <= '0;
    end else if (abort) begin
      byte_cnt <= '0;
      waddr    <= base;
      lanes    <= '0;
    end else if (store) begin
      byte_cnt <= cnt_after;
      acc      <= acc_after;
      if (word_done) begin
        lanes <= LANE_NONE;
        waddr <= waddr_at + WORD_STEP;
      end else begin
        lanes <= lane_at + 3'h1;
        waddr <= waddr_at;
      end
    end else if (flush_part) begin
      lanes <= LANE_NONE;
    end
  end

  // ---------------------------------------------------------------
  // Memory write port
  // ---------------------------------------------------------------
  // Full words go out as soon as their fourth byte lands; the leftover
  // bytes go out once, with only their lanes enabled.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wr_valid <= 1'b0;
      mem_wr_o <= '0;
    end else if (word_done) begin
      wr_valid      <= 1'b1;
      mem_wr_o.addr <= waddr_at;
      mem_wr_o.data <= acc_after;
      mem_wr_o.be   <= BE_ALL;
    end else if (flush_part) begin
      wr_valid      <= 1'b1;
      mem_wr_o.addr <= waddr;
      mem_wr_o.data <= acc;
      mem_wr_o.be   <= lane_mask(lanes);
    end else if (mem_wr_ready_i) begin
      wr_valid <= 1'b0;
    end
  end

  assign mem_wr_valid_o = wr_valid;
  assign chan_ready_o   = (state == TPC_IDLE);
  assign chan_ack_o     = (state == TPC_DONE);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_null_not_stored: assert property (
    push |-> byte_edge && link_s3[LK_VALID])
    else $error("null byte or off-edge byte stored");
  a_full_drops: assert property (
    (byte_edge && link_s3[LK_VALID] && !in_ready) |-> drop_o && !push)
    else $error("byte not dropped on full fifo");
  a_edge_link_side: assert property (
    (push && in_entry.start) |-> !prev_start && link_s3[LK_START])
    else $error("start flag without a rising packet start");
  a_error_gated: assert property (
    (push && !link_s3[LK_START]) |-> !in_entry.err)
    else $error("error kept outside a packet");
  a_start_by_chan: assert property (
    (state == TPC_IDLE && !chan_valid_i) |=> state == TPC_IDLE)
    else $error("capture began without a request");
  a_hunt_discard: assert property (
    (state == TPC_HUNT && pop && !out_entry.start) |=> state == TPC_HUNT
      && byte_cnt == COUNT_NONE)
    else $error("byte kept before packet start");
  a_err_start_skip: assert property (
    (state == TPC_HUNT && pop && out_entry.err) |=> state == TPC_HUNT)
    else $error("packet with error start was captured");
  a_err_abort: assert property (
    (state == TPC_CAPT && abort) |=> state == TPC_HUNT && byte_cnt == COUNT_NONE
      && waddr == base)
    else $error("error did not abort capture");
  a_restart_same: assert property (
    (state == TPC_CAPT && first) |=> byte_cnt == COUNT_ONE
      && lanes == 3'h1 && waddr == base)
    else $error("restart did not return to buffer base");
  a_full_word: assert property (
    word_done |=> wr_valid && mem_wr_o.be == BE_ALL
      && mem_wr_o.data == $past(acc_after))
    else $error("full word write missing");
  a_partial_flush: assert property (
    flush_part |=> wr_valid && mem_wr_o.be == lane_mask($past(lanes))
      && lanes == LANE_NONE)
    else $error("partial flush wrong");
  a_ack_after_write: assert property (
    chan_ack_o |-> !wr_valid && lanes == LANE_NONE
      && $past(state) == TPC_FLUSH)
    else $error("acknowledge before data written");

  c_whole_packet: cover property (chan_ack_o && size != COUNT_NONE);
  c_restart: cover property (state == TPC_CAPT && first);
  c_drop: cover property (drop_o);

endmodule : tpc_capture

// file: tb/tpc_src_model.sv
// Behavioural model of the stream front end that feeds the capture block.
`timescale 1ns/1ps
module tpc_src_model
  import tpc_pkg::*;
(
  input  wire logic              clk_i,          // System clock, used only for pacing.
  output logic                   byte_clock_o,   // Byte clock, still between bytes.
  output logic                   byte_valid_o,   // High for a real byte.
  output logic      [BYTE_W-1:0] data_o,         // Byte data.
  output logic                   packet_error_o, // Packet error level.
  output logic                   packet_start_o  // Packet start level.
);
  // All lines idle low at time zero.
  initial begin
    {byte_clock_o, byte_valid_o, data_o, packet_error_o, packet_start_o} = '0;
  end

  // One byte takes a 160 ns clock period, 80 ns low and 80 ns high.
  // Lines settle 60 ns ahead of the rise, so back-to-back bytes keep that period.
  task automatic send(input logic [BYTE_W-1:0] d, input logic v, input logic s, input logic e);
    @(negedge clk_i);
    data_o = d;
    byte_valid_o = v;
    packet_start_o = s;
    packet_error_o = e;
    repeat (3) @(negedge clk_i);
    byte_clock_o = 1'b1;
    repeat (4) @(negedge clk_i);
    byte_clock_o = 1'b0;
    // Hold time is over, so stale values are replaced to catch late sampling.
    data_o = ~d;
    byte_valid_o = ~v;
    packet_error_o = ~e;
  endtask : send
endmodule : tpc_src_model

// file: tb/tb_transport_packet_capture.sv
// Self-checking testbench for the transport packet capture block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_transport_packet_capture
  import tpc_pkg::*;
;
  logic              clk_i, nrst_i, chan_valid_i, mem_wr_ready_i, stall;
  logic              chan_ready_o, chan_ack_o, mem_wr_valid_o, drop_o;
  logic              bclk, bval, berr, bstart;
  logic [BYTE_W-1:0] bdata;
  tpc_chan_type      chan_req_i;
  tpc_mem_wr_type    mem_wr_o;
  tpc_mem_wr_type    wq[$];
  int                n_fail, n_checks, n_drop;

  tpc_src_model i_src (.clk_i(clk_i), .byte_clock_o(bclk), .byte_valid_o(bval),
    .data_o(bdata), .packet_error_o(berr), .packet_start_o(bstart));
  tpc_capture i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .stream_byte_clock_i(bclk),
    .stream_byte_valid_i(bval), .stream_data_in_i(bdata), .stream_packet_error_i(berr),
    .stream_packet_start_i(bstart), .chan_valid_i(chan_valid_i), .chan_req_i(chan_req_i),
    .chan_ready_o(chan_ready_o), .chan_ack_o(chan_ack_o), .mem_wr_valid_o(mem_wr_valid_o),
    .mem_wr_o(mem_wr_o), .mem_wr_ready_i(mem_wr_ready_i), .drop_o(drop_o));

  // 50 MHz system clock.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Memory side: logs accepted writes, counts drops, stalls when asked.
  always @(posedge clk_i) begin
    if (mem_wr_valid_o === 1'b1 && mem_wr_ready_i === 1'b1) wq.push_back(mem_wr_o);
    if (drop_o === 1'b1) n_drop++;
  end
  always @(negedge clk_i) mem_wr_ready_i <= ~stall;

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic chan(input logic [ADDR_W-1:0] b, input logic [SIZE_W-1:0] s);
    int k;
    @(negedge clk_i);
    chan_valid_i = 1'b1;
    chan_req_i = '{base: b, size: s};
    for (k = 0; chan_ready_o !== 1'b1; k++) begin
      if (k > 50) begin n_fail++; end_sim(); end
      @(negedge clk_i);
    end
    @(negedge clk_i);
    chan_valid_i = 1'b0;
    `CHK("busy", 1'b0, chan_ready_o)
  endtask : chan

  task automatic wait_ack;
    int k;
    for (k = 0; chan_ack_o !== 1'b1; k++) begin
      if (k > 3000) begin n_fail++; end_sim(); end
      @(negedge clk_i);
    end
  endtask : wait_ack

  // Pops one logged write; unused lanes are zeroed so only written bytes count.
  task automatic exp_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] be);
    tpc_mem_wr_type g;
    g = '0;
    if (wq.size() > 0) g = wq.pop_front();
    for (int i = 0; i < 4; i++) if (g.be[i] !== 1'b1) g.data[8*i+:8] = 8'h00;
    `CHK("wr", tpc_mem_wr_type'({a, d, be}), g)
  endtask : exp_wr

  task automatic pkt(input logic [BYTE_W-1:0] d0, input int n);
    for (int i = 0; i < n; i++) i_src.send(d0 + 8'(i), 1'b1, i == 0, 1'b0);
  endtask : pkt

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_basic;
    stall = 1'b1;
    i_src.send(8'hAA, 1'b1, 1'b0, 1'b0);
    i_src.send(8'hAB, 1'b1, 1'b0, 1'b0);
    chan(32'h0000_0100, 16'h0005);
    i_src.send(8'h10, 1'b1, 1'b1, 1'b0);
    i_src.send(8'h11, 1'b1, 1'b0, 1'b0);
    i_src.send(8'hEE, 1'b0, 1'b0, 1'b0);
    pkt_tail();
    repeat (20) @(negedge clk_i);
    `CHK("early_ack", 1'b0, chan_ack_o)
    stall = 1'b0;
    wait_ack();
    exp_wr(32'h0000_0100, 32'h1312_1110, 4'hf);
    exp_wr(32'h0000_0104, 32'h0000_0014, 4'h1);
    `CHK("extra", 0, wq.size())
    $display("done t_basic");
  endtask : t_basic

  task automatic pkt_tail;
    for (int i = 0; i < 3; i++) i_src.send(8'h12 + 8'(i), 1'b1, 1'b0, 1'b0);
  endtask : pkt_tail

  task automatic t_restart;
    chan(32'h0000_0200, 16'h0006);
    pkt(8'h30, 3);
    pkt(8'h40, 6);
    wait_ack();
    exp_wr(32'h0000_0200, 32'h4342_4140, 4'hf);
    exp_wr(32'h0000_0204, 32'h0000_4544, 4'h3);
    `CHK("extra", 0, wq.size())
    $display("done t_restart");
  endtask : t_restart

  task automatic t_error;
    chan(32'h0000_0300, 16'h0004);
    i_src.send(8'h50, 1'b1, 1'b1, 1'b0);
    i_src.send(8'h51, 1'b1, 1'b1, 1'b1);
    i_src.send(8'h52, 1'b1, 1'b0, 1'b0);
    i_src.send(8'h60, 1'b1, 1'b1, 1'b1);
    i_src.send(8'h61, 1'b1, 1'b0, 1'b0);
    i_src.send(8'h70, 1'b1, 1'b1, 1'b0);
    i_src.send(8'h71, 1'b1, 1'b0, 1'b1);
    i_src.send(8'h72, 1'b1, 1'b0, 1'b0);
    i_src.send(8'h73, 1'b1, 1'b0, 1'b0);
    wait_ack();
    exp_wr(32'h0000_0300, 32'h7372_7170, 4'hf);
    `CHK("extra", 0, wq.size())
    $display("done t_error");
  endtask : t_error

  // With no transfer running, 85 bytes overfill 80 entries plus the read stage.
  task automatic t_fill;
    int d0;
    d0 = n_drop;
    for (int i = 0; i < 85; i++) i_src.send(8'(i), 1'b1, 1'b0, 1'b0);
    `CHK("drops", 4, n_drop - d0)
    chan(32'h0000_0400, 16'h0004);
    pkt(8'h80, 4);
    wait_ack();
    exp_wr(32'h0000_0400, 32'h8382_8180, 4'hf);
    $display("done t_fill");
  endtask : t_fill

  // A zero-length request is answered without touching memory.
  task automatic t_empty;
    chan(32'h0000_0500, 16'h0000);
    wait_ack();
    `CHK("empty", 0, wq.size())
    $display("done t_empty");
  endtask : t_empty

  // A whole 188-byte packet with 16 scattered nulls goes out as 47 full words.
  task automatic t_full;
    chan(32'h0000_0600, 16'h00bc);
    for (int i = 0; i < 188; i++) begin
      if (i % 12 == 6) i_src.send(8'hff, 1'b0, 1'b0, 1'b0);
      i_src.send(8'(i), 1'b1, i == 0, 1'b0);
    end
    wait_ack();
    for (int w = 0; w < 47; w++) begin
      exp_wr(32'h0000_0600 + 32'(4 * w), {8'(4*w+3), 8'(4*w+2), 8'(4*w+1), 8'(4*w)}, 4'hf);
    end
    `CHK("extra", 0, wq.size())
    $display("done t_full");
  endtask : t_full

  // Reset, then the scenarios in turn.
  initial begin
    {nrst_i, chan_valid_i, stall} = '0;
    chan_req_i = '0;
    {n_fail, n_checks} = '0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    nrst_i = 1'b1;
    `CHK("idle_ready", 1'b1, chan_ready_o)
    `CHK("idle_wr", 1'b0, mem_wr_valid_o)
    t_basic();
    t_restart();
    t_error();
    t_fill();
    t_empty();
    t_full();
    end_sim();
  end

  // Overall guard against a hang.
  initial begin
    #1_900_000;
    n_fail++;
    end_sim();
  end
endmodule : tb_transport_packet_capture
